//--- common/sesv_pkg.sv
// Purpose: Shared constants and types of the supervisor exception status block
// Assumes: One system clock; attributes reached by Get/Set requests on the device side
// Notes:   Attribute identifiers double as register addresses

// ==========================================================================
// Package
package sesv_pkg;
   // Attribute identifiers
   localparam logic [7:0] SESV_ATTR_FW_REV = 8'h07;
   localparam logic [7:0] SESV_ATTR_STATE = 8'h0B;
   localparam logic [7:0] SESV_ATTR_SUMMARY = 8'h0C;
   localparam logic [7:0] SESV_ATTR_DET_ALARM = 8'h0D;
   localparam logic [7:0] SESV_ATTR_DET_WARN = 8'h0E;
   localparam logic [7:0] SESV_ATTR_ALARM_EN = 8'h0F;
   localparam logic [7:0] SESV_ATTR_WARN_EN = 8'h10;

   // Reset value and largest accepted Set value of the enable settings
   localparam logic SESV_ENABLE_RESET = 1'b1;
   localparam logic [7:0] SESV_BOOL_MAX = 8'h01;

   // Detail group sizes in bytes
   localparam int SESV_COM_BYTES = 2;
   localparam int SESV_DEV_BYTES = 5;
   localparam int SESV_MFR_BYTES = 1;
   localparam logic [7:0] SESV_COM_SIZE = 8'h02;
   localparam logic [7:0] SESV_DEV_SIZE = 8'h05;
   localparam logic [7:0] SESV_MFR_SIZE = 8'h01;
   // Serialised detail structure: three size bytes plus all detail bytes
   localparam logic [7:0] SESV_DET_LEN = 8'h0B;

   // Summary byte layout
   localparam int SESV_SUM_ALARM_LO = 0;
   localparam int SESV_SUM_ZERO = 3;
   localparam int SESV_SUM_WARN_LO = 4;
   localparam int SESV_SUM_FORMAT = 7;

   // Firmware revision string
   localparam logic [7:0] SESV_CHAR_ZERO = 8'h30;
   localparam logic [7:0] SESV_CHAR_POINT = 8'h2E;
   localparam logic [7:0] SESV_FW_LEN = 8'h04;
   localparam logic [7:0] SESV_DECIMAL = 8'h0A;

   // Operational state codes follow declaration order: 0 to 6
   typedef enum logic [2:0] {
      SESV_UNDEFINED,
      SESV_SELF_TEST,
      SESV_IDLE,
      SESV_TEST_EXC,
      SESV_EXECUTING,
      SESV_ABORT,
      SESV_CRIT_FAULT
   } sesv_state_t;

   typedef struct packed {
      logic [SESV_MFR_BYTES*8-1:0] mfr;
      logic [SESV_DEV_BYTES*8-1:0] dev;
      logic [SESV_COM_BYTES*8-1:0] com;
   } sesv_detail_t;

   typedef struct packed {
      logic get;
      logic set;
      logic [7:0] attr;
      logic [7:0] index;
      logic [7:0] data;
   } sesv_req_t;

   typedef struct packed {
      logic valid;
      logic error;
      logic [7:0] data;
   } sesv_resp_t;
endpackage : sesv_pkg

//--- verilog/sesv_detail_group.sv
// Purpose: One exception detail group with its summary OR
// Assumes: Condition bits come from logic on the same clock
// Notes:   Clear wins over hold and conditions while the clock enable is high; a disabled group reads zero

`timescale 1ns/10ps

// ==========================================================================
// Detail group
module sesv_detail_group #(
   parameter int BYTES = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Control
   input wire logic i_clear,
   input wire logic i_hold,
   input wire logic i_enable,
   // Conditions and result
   input wire logic [BYTES*8-1:0] i_cond,
   output logic [BYTES*8-1:0] o_detail,
   output logic o_any
);
   logic [BYTES*8-1:0] detail;
   logic [BYTES*8-1:0] next_detail;

   always_comb begin
      next_detail = detail;
      if (i_clear || !i_enable) begin
         next_detail = '0;
      end else if (!i_hold) begin
         next_detail = i_cond;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         detail <= '0;
      end else if (i_ce) begin
         detail <= next_detail;
      end
   end

   assign o_detail = detail;
   assign o_any = |detail;

   a_group_gate: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_enable) |=> (o_detail == '0 && !o_any))
      else $error("disabled detail group not zero");
endmodule : sesv_detail_group

//--- verilog/sesv_supervisor.sv
// Purpose: Supervisor status block: state code, enables, detail and summary
// Assumes: Get/Set requests and events come from logic on the same clock
// Notes:   One request per cycle; answer one cycle later
//
// Contract
// - Warning detail: three sized groups, read only
// - Alarm enable setting, writable, defaults one
// - Warning enable setting, writable, defaults one
// - Firmware revision reads major dot minor
// - State codes zero to six as listed
// - Entering self test clears all exception bits
// - Self-test fault enters state three, keeps details
// - Abort stays until a recover request or a critical fault
// - Critical fault is never left
// - Only executing counts as non-safe
// - Summary bit seven always reads one
// - Summary bit is OR of its group
// - Summary layout: alarms low, zero, warnings high
// - Summary is a read-only byte
// - State code is a read-only byte

`timescale 1ns/10ps

// ==========================================================================
// Top module
module sesv_supervisor #(
   parameter logic [3:0] FW_MAJOR = 4'h1,
   parameter logic [6:0] FW_MINOR = 7'h04
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Attribute access
   input wire sesv_pkg::sesv_req_t i_req,
   output sesv_pkg::sesv_resp_t o_resp,
   // Detected conditions
   input wire sesv_pkg::sesv_detail_t i_alarm_cond,
   input wire sesv_pkg::sesv_detail_t i_warn_cond,
   // State events
   input wire logic i_selftest_pass,
   input wire logic i_selftest_fault,
   input wire logic i_run_request,
   input wire logic i_stop_request,
   input wire logic i_abort_request,
   input wire logic i_recover_request,
   input wire logic i_retest_request,
   input wire logic i_critical_fault,
   // Status
   output logic [7:0] o_state,
   output logic [7:0] o_summary,
   output logic o_safe,
   output logic o_ready
);
   import sesv_pkg::*;

   localparam logic [7:0] FW_CH_MAJOR = 8'(SESV_CHAR_ZERO + 8'(FW_MAJOR));
   localparam logic [7:0] FW_CH_TENS = 8'(SESV_CHAR_ZERO + 8'(FW_MINOR) / SESV_DECIMAL);
   localparam logic [7:0] FW_CH_UNITS = 8'(SESV_CHAR_ZERO + 8'(FW_MINOR) % SESV_DECIMAL);

   // ==========================================================================
   // State machine
   sesv_state_t state;
   sesv_state_t next_state;
   logic enter_test;
   logic hold_detail;

   always_comb begin
      next_state = state;
      case (state)
         SESV_UNDEFINED: begin
            next_state = SESV_SELF_TEST;
         end
         SESV_SELF_TEST: begin
            if (i_selftest_fault) begin
               next_state = SESV_TEST_EXC;
            end else if (i_selftest_pass) begin
               next_state = SESV_IDLE;
            end
         end
         SESV_IDLE: begin
            if (i_abort_request) begin
               next_state = SESV_ABORT;
            end else if (i_run_request) begin
               next_state = SESV_EXECUTING;
            end
         end
         SESV_TEST_EXC: begin
            if (i_retest_request) begin
               next_state = SESV_SELF_TEST;
            end
         end
         SESV_EXECUTING: begin
            if (i_abort_request) begin
               next_state = SESV_ABORT;
            end else if (i_stop_request) begin
               next_state = SESV_IDLE;
            end
         end
         SESV_ABORT: begin
            if (i_recover_request) begin
               next_state = SESV_IDLE;
            end
         end
         SESV_CRIT_FAULT: begin
            next_state = SESV_CRIT_FAULT;
         end
         default: begin
            next_state = SESV_UNDEFINED;
         end
      endcase
      if (i_critical_fault && state != SESV_UNDEFINED) begin
         next_state = SESV_CRIT_FAULT;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= SESV_UNDEFINED;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   // Clear on the entry edge only, so a fault caught later in self test survives
   assign enter_test = (next_state == SESV_SELF_TEST) && (state != SESV_SELF_TEST);
   // Self-test particulars stay frozen while the exception state holds
   assign hold_detail = (state == SESV_TEST_EXC);

   // ==========================================================================
   // Enable settings
   logic alarm_en;
   logic warn_en;
   logic next_alarm_en;
   logic next_warn_en;
   logic set_ok;

   assign set_ok = i_req.set && (i_req.data <= SESV_BOOL_MAX);

   always_comb begin
      next_alarm_en = alarm_en;
      next_warn_en = warn_en;
      if (set_ok && i_req.attr == SESV_ATTR_ALARM_EN) begin
         next_alarm_en = i_req.data[0];
      end
      if (set_ok && i_req.attr == SESV_ATTR_WARN_EN) begin
         next_warn_en = i_req.data[0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         alarm_en <= SESV_ENABLE_RESET;
         warn_en <= SESV_ENABLE_RESET;
      end else if (i_ce) begin
         alarm_en <= next_alarm_en;
         warn_en <= next_warn_en;
      end
   end

   // ==========================================================================
   // Detail groups
   sesv_detail_t alarm_det;
   sesv_detail_t warn_det;
   logic [2:0] alarm_any;
   logic [2:0] warn_any;

   sesv_detail_group #(.BYTES(SESV_COM_BYTES)) u_alarm_com (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_clear(enter_test), .i_hold(hold_detail),
      .i_enable(alarm_en), .i_cond(i_alarm_cond.com), .o_detail(alarm_det.com), .o_any(alarm_any[0]));
   sesv_detail_group #(.BYTES(SESV_DEV_BYTES)) u_alarm_dev (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_clear(enter_test), .i_hold(hold_detail),
      .i_enable(alarm_en), .i_cond(i_alarm_cond.dev), .o_detail(alarm_det.dev), .o_any(alarm_any[1]));
   sesv_detail_group #(.BYTES(SESV_MFR_BYTES)) u_alarm_mfr (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_clear(enter_test), .i_hold(hold_detail),
      .i_enable(alarm_en), .i_cond(i_alarm_cond.mfr), .o_detail(alarm_det.mfr), .o_any(alarm_any[2]));
   sesv_detail_group #(.BYTES(SESV_COM_BYTES)) u_warn_com (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_clear(enter_test), .i_hold(hold_detail),
      .i_enable(warn_en), .i_cond(i_warn_cond.com), .o_detail(warn_det.com), .o_any(warn_any[0]));
   sesv_detail_group #(.BYTES(SESV_DEV_BYTES)) u_warn_dev (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_clear(enter_test), .i_hold(hold_detail),
      .i_enable(warn_en), .i_cond(i_warn_cond.dev), .o_detail(warn_det.dev), .o_any(warn_any[1]));
   sesv_detail_group #(.BYTES(SESV_MFR_BYTES)) u_warn_mfr (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_clear(enter_test), .i_hold(hold_detail),
      .i_enable(warn_en), .i_cond(i_warn_cond.mfr), .o_detail(warn_det.mfr), .o_any(warn_any[2]));

   // ==========================================================================
   // Summary and status outputs
   logic [7:0] summary_now;
   logic [7:0] next_summary;

   always_comb begin
      summary_now = '0;
      summary_now[SESV_SUM_FORMAT] = 1'b1;
      summary_now[SESV_SUM_ZERO] = 1'b0;
      summary_now[SESV_SUM_ALARM_LO +: 3] = alarm_any;
      summary_now[SESV_SUM_WARN_LO +: 3] = warn_any;
      next_summary = summary_now;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_summary <= 8'h01 << SESV_SUM_FORMAT;
         o_state <= 8'(SESV_UNDEFINED);
         o_safe <= 1'b1;
         o_ready <= 1'b0;
      end else if (i_ce) begin
         o_summary <= next_summary;
         o_state <= 8'(state);
         o_safe <= (state != SESV_EXECUTING);
         o_ready <= (state == SESV_IDLE);
      end
   end

   // ==========================================================================
   // Get/Set answers
   logic [SESV_DET_LEN*8-1:0] alarm_vec;
   logic [SESV_DET_LEN*8-1:0] warn_vec;
   sesv_resp_t next_resp;

   // Byte 0 in the low bits: size, detail bytes, per group in order
   assign alarm_vec = {alarm_det.mfr, SESV_MFR_SIZE, alarm_det.dev, SESV_DEV_SIZE, alarm_det.com, SESV_COM_SIZE};
   assign warn_vec = {warn_det.mfr, SESV_MFR_SIZE, warn_det.dev, SESV_DEV_SIZE, warn_det.com, SESV_COM_SIZE};

   always_comb begin
      next_resp = '0;
      next_resp.valid = i_req.get || i_req.set;
      if (i_req.set) begin
         // Only the two enables take writes; other values of a boolean are refused
         next_resp.error = !set_ok ||
            !(i_req.attr == SESV_ATTR_ALARM_EN || i_req.attr == SESV_ATTR_WARN_EN);
      end else if (i_req.get) begin
         case (i_req.attr)
            SESV_ATTR_STATE: next_resp.data = o_state;
            SESV_ATTR_SUMMARY: next_resp.data = o_summary;
            SESV_ATTR_ALARM_EN: next_resp.data = {7'h00, alarm_en};
            SESV_ATTR_WARN_EN: next_resp.data = {7'h00, warn_en};
            SESV_ATTR_DET_ALARM, SESV_ATTR_DET_WARN: begin
               if (i_req.index < SESV_DET_LEN) begin
                  next_resp.data = (i_req.attr == SESV_ATTR_DET_ALARM) ?
                     alarm_vec[i_req.index*8 +: 8] : warn_vec[i_req.index*8 +: 8];
               end else begin
                  next_resp.error = 1'b1;
               end
            end
            SESV_ATTR_FW_REV: begin
               case (i_req.index)
                  8'h00: next_resp.data = FW_CH_MAJOR;
                  8'h01: next_resp.data = SESV_CHAR_POINT;
                  8'h02: next_resp.data = FW_CH_TENS;
                  8'h03: next_resp.data = FW_CH_UNITS;
                  default: next_resp.error = 1'b1;
               endcase
            end
            default: next_resp.error = 1'b1;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_resp <= '0;
      end else if (i_ce) begin
         o_resp <= next_resp;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_fault_in_test;
      i_ce && state == SESV_SELF_TEST && i_selftest_fault;
   endsequence

   a_summary_format: assert property (o_summary[SESV_SUM_FORMAT] && !o_summary[SESV_SUM_ZERO])
      else $error("summary format bit or zero bit wrong");
   a_summary_or: assert property (i_ce |=> o_summary == $past({1'b1, |warn_det.mfr, |warn_det.dev, |warn_det.com,
      1'b0, |alarm_det.mfr, |alarm_det.dev, |alarm_det.com}))
      else $error("summary does not follow details");
   a_summary_alarm: assert property (i_ce && alarm_det.com != '0 |=> o_summary[SESV_SUM_ALARM_LO])
      else $error("common alarm not in summary bit 0");
   a_fault_capture: assert property (s_fault_in_test ##1 i_ce && !i_critical_fault && !i_retest_request && alarm_en
      |=> state == SESV_TEST_EXC && alarm_det == $past(alarm_det))
      else $error("self-test fault not held in exception state");
   a_entry_clears: assert property (i_ce && enter_test |=> alarm_det == '0 && warn_det == '0)
      else $error("details not cleared on self test entry");
   a_abort_holds: assert property (state == SESV_ABORT && !i_recover_request && !i_critical_fault
      |=> state == SESV_ABORT)
      else $error("abort left without recover");
   a_critical_sticky: assert property (state == SESV_CRIT_FAULT |=> state == SESV_CRIT_FAULT)
      else $error("critical fault state left");
   a_safe_flag: assert property (i_ce |=> o_safe == ($past(state) != SESV_EXECUTING))
      else $error("safe flag wrong");
   a_enable_gate: assert property ((i_ce && !alarm_en && !next_alarm_en) ##1 (i_ce && !alarm_en)
      |=> o_summary[SESV_SUM_ALARM_LO +: 3] == 3'h0)
      else $error("alarm summary set while disabled");
   a_set_enable: assert property (i_ce && set_ok && i_req.attr == SESV_ATTR_WARN_EN
      |=> warn_en == $past(i_req.data[0]))
      else $error("warning enable not written");
   a_enable_reset: assert property ($fell(i_rst) |-> alarm_en && warn_en)
      else $error("enable settings not at default after reset");
endmodule : sesv_supervisor

//--- bench/sesv_master.sv
// Purpose: Fieldbus master model issuing Get/Set requests to the supervisor
// Assumes: Requests launch just after a rising edge; answer one edge after take
// Notes:   Released request fields show inverted data, never the last value

`timescale 1ns/10ps

// ==========================================================================
// Master model
module sesv_master
   import sesv_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Attribute access
   input wire sesv_pkg::sesv_resp_t i_resp,
   output sesv_pkg::sesv_req_t o_req
);
   initial o_req = '0;

   // One Get or Set; ok low when no answer came within the bound
   task automatic xfer(input logic wr, input logic [7:0] attr, input logic [7:0] idx,
                       input logic [7:0] wdata, output logic [7:0] rdata, output logic err,
                       output logic ok);
      sesv_req_t r;
      r = '0;
      r.get = ~wr;
      r.set = wr;
      r.attr = attr;
      r.index = idx;
      r.data = wdata;
      ok = 1'b0;
      err = 1'b1;
      rdata = 8'h00;
      @(posedge i_clk);
      o_req <= r;
      @(posedge i_clk);
      o_req <= {1'b0, 1'b0, ~attr, ~idx, ~wdata};
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge i_clk);
         if (i_resp.valid === 1'b1) begin
            ok = 1'b1;
            rdata = i_resp.data;
            err = i_resp.error;
         end
      end
   endtask : xfer
endmodule : sesv_master

//--- bench/test_sesv_supervisor.sv
// Purpose: Self-checking bench of the supervisor status block
// Assumes: Event bits are one-cycle pulses; state and summary lag as documented
// Notes:   Walks attribute access, summary forming, enables and all state codes

`timescale 1ns/10ps

// ==========================================================================
// Testbench
module test_supervisor_exception_status;
   import sesv_pkg::*;
   localparam int EV_PASS = 0, EV_FAULT = 1, EV_RUN = 2, EV_STOP = 3;
   localparam int EV_ABORT = 4, EV_RECOVER = 5, EV_RETEST = 6, EV_CRIT = 7;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   sesv_req_t req;
   sesv_resp_t resp;
   sesv_detail_t alarm_c = '0;
   sesv_detail_t warn_c = '0;
   logic [7:0] ev = 8'h00;
   logic [7:0] o_state;
   logic [7:0] o_summary;
   logic o_safe;
   logic o_ready;
   int errors = 0;
   int samples_checked = 0;

   always #10 i_clk = ~i_clk;

   sesv_master i_master (.i_clk(i_clk), .i_resp(resp), .o_req(req));

   sesv_supervisor i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(req), .o_resp(resp),
      .i_alarm_cond(alarm_c), .i_warn_cond(warn_c),
      .i_selftest_pass(ev[EV_PASS]), .i_selftest_fault(ev[EV_FAULT]), .i_run_request(ev[EV_RUN]),
      .i_stop_request(ev[EV_STOP]), .i_abort_request(ev[EV_ABORT]), .i_recover_request(ev[EV_RECOVER]),
      .i_retest_request(ev[EV_RETEST]), .i_critical_fault(ev[EV_CRIT]),
      .o_state(o_state), .o_summary(o_summary), .o_safe(o_safe), .o_ready(o_ready)
   );

   // ==========================================================================
   // Helpers
   task automatic results();
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic access(input logic wr, input logic [7:0] attr, input logic [7:0] idx,
                         input logic [7:0] wdata, input logic [7:0] exp, input logic exp_err);
      logic [7:0] rd;
      logic er;
      logic ok;
      i_master.xfer(wr, attr, idx, wdata, rd, er, ok);
      if (!ok) begin
         errors++;
         results();
      end
      chk({7'h00, er}, {7'h00, exp_err});
      if (!wr) begin
         chk(rd, exp);
      end
   endtask : access

   task automatic pulse(input int b);
      @(posedge i_clk);
      ev <= 8'h01 << b;
      @(posedge i_clk);
      ev <= 8'h00;
   endtask : pulse

   task automatic state_chk(input logic [7:0] code);
      repeat (2) @(posedge i_clk);
      chk(o_state, code);
      chk({7'h00, o_safe}, {7'h00, code != 8'h04});
      chk({7'h00, o_ready}, {7'h00, code == 8'h02});
   endtask : state_chk

   // ==========================================================================
   // Main sequence
   initial begin
      sesv_detail_t a;
      sesv_detail_t w;
      int pos;
      repeat (20) @(posedge i_clk);
      chk(o_summary, 8'h80);
      chk(o_state, 8'h00);
      @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      state_chk(8'h01);
      access(1'b0, SESV_ATTR_STATE, 8'h00, 8'h00, 8'h01, 1'b0);
      access(1'b0, SESV_ATTR_ALARM_EN, 8'h00, 8'h00, 8'h01, 1'b0);
      access(1'b0, SESV_ATTR_WARN_EN, 8'h00, 8'h00, 8'h01, 1'b0);
      access(1'b1, SESV_ATTR_ALARM_EN, 8'h00, 8'h02, 8'h00, 1'b1);
      access(1'b0, SESV_ATTR_ALARM_EN, 8'h00, 8'h00, 8'h01, 1'b0);
      access(1'b1, SESV_ATTR_STATE, 8'h00, 8'h01, 8'h00, 1'b1);
      access(1'b1, SESV_ATTR_SUMMARY, 8'h00, 8'h01, 8'h00, 1'b1);
      access(1'b1, SESV_ATTR_DET_WARN, 8'h00, 8'h01, 8'h00, 1'b1);
      access(1'b0, 8'h20, 8'h00, 8'h00, 8'h00, 1'b1);
      access(1'b0, SESV_ATTR_FW_REV, 8'h00, 8'h00, 8'h31, 1'b0);
      access(1'b0, SESV_ATTR_FW_REV, 8'h01, 8'h00, 8'h2E, 1'b0);
      access(1'b0, SESV_ATTR_FW_REV, 8'h02, 8'h00, 8'h30, 1'b0);
      access(1'b0, SESV_ATTR_FW_REV, 8'h03, 8'h00, 8'h34, 1'b0);
      access(1'b0, SESV_ATTR_FW_REV, 8'h04, 8'h00, 8'h00, 1'b1);
      // One group at a time lights its own summary bit
      for (int g = 0; g < 6; g++) begin
         a = '0;
         w = '0;
         case (g)
            0: a.com[0] = 1'b1;
            1: a.dev[39] = 1'b1;
            2: a.mfr[7] = 1'b1;
            3: w.com[15] = 1'b1;
            4: w.dev[0] = 1'b1;
            default: w.mfr[0] = 1'b1;
         endcase
         pos = (g < 3) ? g : g + 1;
         @(posedge i_clk);
         alarm_c <= a;
         warn_c <= w;
         repeat (3) @(posedge i_clk);
         chk(o_summary, 8'h80 | (8'h01 << pos));
      end
      @(posedge i_clk);
      alarm_c <= '1;
      warn_c <= {8'h00, 40'h00_0000_005A, 16'hC300};
      repeat (3) @(posedge i_clk);
      chk(o_summary, 8'hB7);
      access(1'b0, SESV_ATTR_DET_WARN, 8'h00, 8'h00, 8'h02, 1'b0);
      access(1'b0, SESV_ATTR_DET_WARN, 8'h02, 8'h00, 8'hC3, 1'b0);
      access(1'b0, SESV_ATTR_DET_WARN, 8'h03, 8'h00, 8'h05, 1'b0);
      access(1'b0, SESV_ATTR_DET_WARN, 8'h04, 8'h00, 8'h5A, 1'b0);
      access(1'b0, SESV_ATTR_DET_WARN, 8'h09, 8'h00, 8'h01, 1'b0);
      access(1'b0, SESV_ATTR_DET_WARN, 8'h0B, 8'h00, 8'h00, 1'b1);
      // Disabled groups read zero even with conditions present
      access(1'b1, SESV_ATTR_ALARM_EN, 8'h00, 8'h00, 8'h00, 1'b0);
      access(1'b1, SESV_ATTR_WARN_EN, 8'h00, 8'h00, 8'h00, 1'b0);
      repeat (3) @(posedge i_clk);
      chk(o_summary, 8'h80);
      access(1'b0, SESV_ATTR_DET_ALARM, 8'h01, 8'h00, 8'h00, 1'b0);
      access(1'b0, SESV_ATTR_ALARM_EN, 8'h00, 8'h00, 8'h00, 1'b0);
      access(1'b1, SESV_ATTR_ALARM_EN, 8'h00, 8'h01, 8'h00, 1'b0);
      access(1'b1, SESV_ATTR_WARN_EN, 8'h00, 8'h01, 8'h00, 1'b0);
      repeat (3) @(posedge i_clk);
      chk(o_summary, 8'hB7);
      // Self-test fault freezes the captured details
      @(posedge i_clk);
      alarm_c <= {8'h00, 40'h0, 16'h0004};
      warn_c <= '0;
      repeat (3) @(posedge i_clk);
      pulse(EV_FAULT);
      state_chk(8'h03);
      @(posedge i_clk);
      alarm_c <= '0;
      repeat (3) @(posedge i_clk);
      chk(o_summary, 8'h81);
      access(1'b0, SESV_ATTR_DET_ALARM, 8'h01, 8'h00, 8'h04, 1'b0);
      pulse(EV_RETEST);
      state_chk(8'h01);
      chk(o_summary, 8'h80);
      access(1'b0, SESV_ATTR_DET_ALARM, 8'h01, 8'h00, 8'h00, 1'b0);
      pulse(EV_PASS);
      state_chk(8'h02);
      pulse(EV_RUN);
      state_chk(8'h04);
      pulse(EV_ABORT);
      state_chk(8'h05);
      pulse(EV_RUN);
      repeat (8) @(posedge i_clk);
      state_chk(8'h05);
      pulse(EV_RECOVER);
      state_chk(8'h02);
      pulse(EV_RUN);
      state_chk(8'h04);
      pulse(EV_STOP);
      state_chk(8'h02);
      pulse(EV_CRIT);
      state_chk(8'h06);
      for (int b = 0; b < 7; b++) begin
         pulse(b);
      end
      state_chk(8'h06);
      access(1'b0, SESV_ATTR_STATE, 8'h00, 8'h00, 8'h06, 1'b0);
      // Clock enable low freezes details and summary
      @(posedge i_clk);
      i_ce <= 1'b0;
      alarm_c <= {8'h00, 40'h0, 16'h0001};
      repeat (3) @(posedge i_clk);
      chk(o_summary, 8'h80);
      i_ce <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk(o_summary, 8'h81);
      results();
   end
endmodule : test_supervisor_exception_status
